// file: pkg/wdog_pkg.sv
package wdog_pkg;
   // Register map (word index on plain port)
   localparam logic [1:0] ADDR_CTRL   = 2'h0;
   localparam logic [1:0] ADDR_STATUS = 2'h1;
   localparam logic [1:0] ADDR_MASK   = 2'h2;
   localparam logic [1:0] ADDR_COUNT  = 2'h3;
   localparam int         ADDR_W      = 2;
   localparam int         DATA_W      = 8;
   // Control register fields
   localparam int         EN_BIT      = 0;
   localparam int         PS_LSB      = 1;
   localparam int         PS_W        = 5;
   localparam logic [4:0] PS_MAX      = 5'h12;
   localparam logic [4:0] PS_MIN      = 5'h00;
   localparam logic [4:0] PS_ALL_ONES = 5'h1f;
   localparam logic [4:0] PS_DEFAULT  = 5'h0b;
   localparam int         BASE_SHIFT  = 5;
   localparam int         CNT_W       = 24;
   // Config enable field codes
   localparam logic [1:0] CFG_EN_OFF  = 2'h0;
   localparam logic [1:0] CFG_EN_SW   = 2'h1;
   // Status bits
   localparam int         ST_TIMEOUT  = 0;
   localparam int         ST_WAKE     = 1;
   localparam int         ST_W        = 2;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } bus_req_t;
endpackage

// file: hw/wdog_ctrl.sv
`timescale 1ns/1ns
// Contract
// - Timeout equals 2^(5+N) slow-oscillator periods for period code N of 0 to 18.
// - Period codes 19 to 31 act as the minimum 1:32 prescale.
// - At reset the period code loads 01011 if the config period is 11111, else the config.
// - When the config period is not 11111 the period code is read-only.
// - With config enable 01 the software enable bit starts and stops the timer.
// - With config enable 1x or 00 the software bit is ignored and config alone governs.
// - The prescaler counts ticks of the 31 kHz low-frequency oscillator.
// - Control bits 7 and 6 read zero and ignore writes.
// - The counter clears on every wake from sleep.
module wdog_ctrl (
   // Clock and reset
   input  wire logic                          i_mclk,
   input  wire logic                          i_rst_n,
   // Register port
   input  wire wdog_pkg::bus_req_t            i_bus,
   output logic      [wdog_pkg::DATA_W-1:0]   o_rdata,
   // Configuration word and system
   input  wire logic [wdog_pkg::PS_W-1:0]     i_config_period_select,
   input  wire logic [1:0]                    i_config_dog_enable,
   input  wire logic                          i_low_freq_internal_osc,
   input  wire logic                          i_sleep,
   input  wire logic                          i_dog_clear,
   // Watchdog outputs
   output logic                               o_dog_running,
   output logic                               o_dog_timeout,
   output logic                               o_irq
);
   logic [wdog_pkg::PS_W-1:0]   ps_q,   ps_d;
   logic                        en_q,   en_d;
   logic [wdog_pkg::CNT_W-1:0]  cnt_q,  cnt_d;
   logic [wdog_pkg::ST_W-1:0]   st_q,   st_d;
   logic [wdog_pkg::ST_W-1:0]   mask_q, mask_d;
   logic [wdog_pkg::DATA_W-1:0] rd_q,   rd_d;
   logic                        to_q,   to_d;
   logic                        loaded_q, loaded_d;
   logic [2:0]                  osc_sync_q, osc_sync_d;
   logic [1:0]                  slp_sync_q, slp_sync_d;
   logic                        slp_prev_q, slp_prev_d;
   logic                        tick, wake, running, ps_writable;
   logic [4:0]                  eff_ps;
   logic [wdog_pkg::CNT_W-1:0]  limit;
   logic [wdog_pkg::ST_W-1:0]   ev;

   // Synchronise slow oscillator and sleep
   always_comb begin
      osc_sync_d = {osc_sync_q[1:0], i_low_freq_internal_osc};
      slp_sync_d = {slp_sync_q[0], i_sleep};
      slp_prev_d = slp_sync_q[1];
   end
   assign tick = osc_sync_q[1] & ~osc_sync_q[2];
   assign wake = slp_prev_q & ~slp_sync_q[1];

   // Enable and period decode
   always_comb begin
      unique case (i_config_dog_enable)
         wdog_pkg::CFG_EN_SW:  running = en_q;
         wdog_pkg::CFG_EN_OFF: running = 1'b0;
         default:              running = 1'b1;
      endcase
   end
   assign ps_writable = (i_config_period_select == wdog_pkg::PS_ALL_ONES);
   assign eff_ps = (ps_q > wdog_pkg::PS_MAX) ? wdog_pkg::PS_MIN : ps_q;
   assign limit  = wdog_pkg::CNT_W'((64'h1 << (eff_ps + wdog_pkg::BASE_SHIFT)) - 64'h1);

   // Register and counter next state
   always_comb begin
      ps_d     = ps_q;
      en_d     = en_q;
      mask_d   = mask_q;
      loaded_d = 1'b1;
      rd_d     = '0;
      cnt_d    = cnt_q;
      to_d     = 1'b0;
      ev       = '0;
      if (!loaded_q) begin
         ps_d = ps_writable ? wdog_pkg::PS_DEFAULT : i_config_period_select;
      end
      if (i_bus.wr) begin
         unique case (i_bus.addr)
            wdog_pkg::ADDR_CTRL: begin
               en_d = i_bus.wdata[wdog_pkg::EN_BIT];
               if (ps_writable && loaded_q) begin
                  ps_d = i_bus.wdata[wdog_pkg::PS_LSB +: wdog_pkg::PS_W];
               end
            end
            wdog_pkg::ADDR_MASK: mask_d = i_bus.wdata[wdog_pkg::ST_W-1:0];
            default: ;
         endcase
      end
      if (i_bus.rd) begin
         unique case (i_bus.addr)
            wdog_pkg::ADDR_CTRL:   rd_d = {2'h0, ps_q, en_q};
            wdog_pkg::ADDR_STATUS: rd_d = wdog_pkg::DATA_W'(st_q);
            wdog_pkg::ADDR_MASK:   rd_d = wdog_pkg::DATA_W'(mask_q);
            default:               rd_d = cnt_q[wdog_pkg::CNT_W-1 -: wdog_pkg::DATA_W];
         endcase
      end
      if (!running || wake || i_dog_clear) begin
         cnt_d = '0;
         ev[wdog_pkg::ST_WAKE] = wake;
      end else if (tick) begin
         if (cnt_q >= limit) begin
            cnt_d = '0;
            to_d  = 1'b1;
            ev[wdog_pkg::ST_TIMEOUT] = 1'b1;
         end else begin
            cnt_d = cnt_q + 1'b1;
         end
      end
      st_d = st_q;
      if (i_bus.wr && i_bus.addr == wdog_pkg::ADDR_STATUS) begin
         st_d = st_q & ~i_bus.wdata[wdog_pkg::ST_W-1:0];
      end
      st_d = st_d | ev;
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ps_q       <= wdog_pkg::PS_DEFAULT;
         en_q       <= 1'b0;
         cnt_q      <= '0;
         st_q       <= '0;
         mask_q     <= '0;
         rd_q       <= '0;
         to_q       <= 1'b0;
         loaded_q   <= 1'b0;
         osc_sync_q <= '0;
         slp_sync_q <= '0;
         slp_prev_q <= 1'b0;
      end else begin
         ps_q       <= ps_d;
         en_q       <= en_d;
         cnt_q      <= cnt_d;
         st_q       <= st_d;
         mask_q     <= mask_d;
         rd_q       <= rd_d;
         to_q       <= to_d;
         loaded_q   <= loaded_d;
         osc_sync_q <= osc_sync_d;
         slp_sync_q <= slp_sync_d;
         slp_prev_q <= slp_prev_d;
      end
   end

   assign o_rdata       = rd_q;
   assign o_dog_timeout = to_q;
   assign o_dog_running = running;
   assign o_irq         = |(st_q & mask_q);

   // Assertions
   logic [wdog_pkg::PS_W-1:0] wr_ps;
   logic                      wr_en;
   assign wr_ps = i_bus.wdata[wdog_pkg::PS_LSB +: wdog_pkg::PS_W];
   assign wr_en = i_bus.wdata[wdog_pkg::EN_BIT];

   sequence s_load;
      $rose(loaded_q);
   endsequence

   sequence s_ctrl_wr;
      i_bus.wr && (i_bus.addr == wdog_pkg::ADDR_CTRL);
   endsequence

   sequence s_ctrl_rd;
      i_bus.rd && (i_bus.addr == wdog_pkg::ADDR_CTRL);
   endsequence

   sequence s_wake_kept;
      st_q[wdog_pkg::ST_WAKE] &&
         !(i_bus.wr && (i_bus.addr == wdog_pkg::ADDR_STATUS) && i_bus.wdata[wdog_pkg::ST_WAKE]);
   endsequence

   sequence s_live_tick;
      running && !wake && !i_dog_clear && tick;
   endsequence

   sequence s_live_idle;
      running && !wake && !i_dog_clear && !tick;
   endsequence

   sequence s_wake_seen;
      (cnt_q == '0) && st_q[wdog_pkg::ST_WAKE];
   endsequence

   property p_rst_ps;
      @(posedge i_mclk) disable iff (!i_rst_n)
      s_load |-> ps_q == (ps_writable ? wdog_pkg::PS_DEFAULT : i_config_period_select);
   endproperty
   a_rst_ps: assert property (p_rst_ps) else $error("period reset load wrong");

   property p_en_rst;
      @(posedge i_mclk) disable iff (!i_rst_n)
      s_load |-> (!en_q || $past(i_bus.wr));
   endproperty
   a_en_rst: assert property (p_en_rst) else $error("enable not zero after reset");

   property p_ro;
      @(posedge i_mclk) disable iff (!i_rst_n)
      (loaded_q && !ps_writable) |=> $stable(ps_q);
   endproperty
   a_ro: assert property (p_ro) else $error("read-only period changed");

   property p_rw;
      @(posedge i_mclk) disable iff (!i_rst_n)
      (loaded_q && ps_writable) ##0 s_ctrl_wr |=> ps_q == $past(wr_ps);
   endproperty
   a_rw: assert property (p_rw) else $error("writable period not written");

   property p_en_wr;
      @(posedge i_mclk) disable iff (!i_rst_n)
      s_ctrl_wr |=> en_q == $past(wr_en);
   endproperty
   a_en_wr: assert property (p_en_wr) else $error("enable bit not written");

   property p_sw;
      @(posedge i_mclk) disable iff (!i_rst_n)
      (i_config_dog_enable == wdog_pkg::CFG_EN_SW) |-> running == en_q;
   endproperty
   a_sw: assert property (p_sw) else $error("software enable not obeyed");

   property p_cfg;
      @(posedge i_mclk) disable iff (!i_rst_n)
      (i_config_dog_enable != wdog_pkg::CFG_EN_SW) |-> running == i_config_dog_enable[1];
   endproperty
   a_cfg: assert property (p_cfg) else $error("config enable not obeyed");

   property p_off;
      @(posedge i_mclk) disable iff (!i_rst_n)
      !running |=> (cnt_q == '0) && !o_dog_timeout;
   endproperty
   a_off: assert property (p_off) else $error("stopped watchdog still counting");

   property p_min;
      @(posedge i_mclk) disable iff (!i_rst_n)
      (ps_q > wdog_pkg::PS_MAX) |-> limit == wdog_pkg::CNT_W'((1 << wdog_pkg::BASE_SHIFT) - 1);
   endproperty
   a_min: assert property (p_min) else $error("reserved code not minimum");

   property p_lim;
      @(posedge i_mclk) disable iff (!i_rst_n)
      (ps_q == wdog_pkg::PS_MIN) |-> limit == wdog_pkg::CNT_W'((1 << wdog_pkg::BASE_SHIFT) - 1);
   endproperty
   a_lim: assert property (p_lim) else $error("period limit wrong");

   property p_lim_top;
      @(posedge i_mclk) disable iff (!i_rst_n)
      (ps_q == wdog_pkg::PS_MAX) |-> limit == wdog_pkg::CNT_W'((1 << (wdog_pkg::CNT_W - 1)) - 1);
   endproperty
   a_lim_top: assert property (p_lim_top) else $error("longest period limit wrong");

   property p_step;
      @(posedge i_mclk) disable iff (!i_rst_n)
      s_live_tick ##0 (cnt_q < limit) |=> cnt_q == $past(cnt_q) + 1'b1;
   endproperty
   a_step: assert property (p_step) else $error("counter missed a slow tick");

   property p_hold;
      @(posedge i_mclk) disable iff (!i_rst_n)
      s_live_idle |=> $stable(cnt_q);
   endproperty
   a_hold: assert property (p_hold) else $error("counter moved without a tick");

   property p_expire;
      @(posedge i_mclk) disable iff (!i_rst_n)
      s_live_tick ##0 (cnt_q >= limit) |=> o_dog_timeout && (cnt_q == '0);
   endproperty
   a_expire: assert property (p_expire) else $error("timeout not raised at limit");

   property p_pulse;
      @(posedge i_mclk) disable iff (!i_rst_n)
      o_dog_timeout |=> !o_dog_timeout;
   endproperty
   a_pulse: assert property (p_pulse) else $error("timeout pulse too long");

   property p_to_st;
      @(posedge i_mclk) disable iff (!i_rst_n)
      o_dog_timeout |-> st_q[wdog_pkg::ST_TIMEOUT];
   endproperty
   a_to_st: assert property (p_to_st) else $error("timeout status not set");

   property p_clear;
      @(posedge i_mclk) disable iff (!i_rst_n)
      i_dog_clear |=> cnt_q == '0;
   endproperty
   a_clear: assert property (p_clear) else $error("counter not cleared");

   property p_wake;
      @(posedge i_mclk) disable iff (!i_rst_n)
      wake |=> s_wake_seen;
   endproperty
   a_wake: assert property (p_wake) else $error("counter not cleared on wake");

   property p_sticky;
      @(posedge i_mclk) disable iff (!i_rst_n)
      s_wake_kept |=> st_q[wdog_pkg::ST_WAKE];
   endproperty
   a_sticky: assert property (p_sticky) else $error("wake status lost");

   property p_one_tick;
      @(posedge i_mclk) disable iff (!i_rst_n)
      tick |=> !tick;
   endproperty
   a_one_tick: assert property (p_one_tick) else $error("slow tick longer than one cycle");

   property p_top;
      @(posedge i_mclk) disable iff (!i_rst_n)
      s_ctrl_rd |=> o_rdata[7:6] == 2'h0;
   endproperty
   a_top: assert property (p_top) else $error("unimplemented bits nonzero");

   property p_rd_ctrl;
      @(posedge i_mclk) disable iff (!i_rst_n)
      s_ctrl_rd |=> o_rdata == {2'h0, $past(ps_q), $past(en_q)};
   endproperty
   a_rd_ctrl: assert property (p_rd_ctrl) else $error("control read data wrong");
endmodule

// file: test/tb.sv
`timescale 1ns/1ns
module tb;
   logic               i_mclk;
   logic               i_rst_n;
   wdog_pkg::bus_req_t i_bus;
   logic [7:0]         o_rdata;
   logic [4:0]         cps;
   logic [1:0]         cen;
   logic               osc, slp, clr, run, tmo, irq;
   logic [7:0]         rv, d;
   int                 n_errors, num_checks, cyc, hit;
   logic [4:0]         codes [5] = '{5'h00, 5'h01, 5'h02, 5'h13, 5'h1f};

   wdog_ctrl dut_u (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_bus(i_bus), .o_rdata(o_rdata),
      .i_config_period_select(cps), .i_config_dog_enable(cen),
      .i_low_freq_internal_osc(osc), .i_sleep(slp), .i_dog_clear(clr),
      .o_dog_running(run), .o_dog_timeout(tmo), .o_irq(irq));

   initial begin
      i_mclk = 1'b0;
      forever #25 i_mclk = ~i_mclk;
   end

   task summarize();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   always @(posedge i_mclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors = n_errors + 1;
         summarize();
      end
   end

   task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Expected tick count to timeout
   function automatic int exp_ticks(input logic [4:0] c);
      return (c > 5'h12) ? 32 : (1 << (5 + c));
   endfunction

   task wr(input logic [1:0] a, input logic [7:0] v);
      @(posedge i_mclk) i_bus <= '{a, v, 1'b1, 1'b0};
      @(posedge i_mclk) i_bus.wr <= 1'b0;
   endtask

   task rd(input logic [1:0] a, output logic [7:0] v);
      @(posedge i_mclk) i_bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge i_mclk) i_bus.rd <= 1'b0;
      @(negedge i_mclk) v = o_rdata;
   endtask

   task do_reset(input logic [4:0] p);
      @(posedge i_mclk) i_rst_n <= 1'b0;
      cps <= p;
      repeat (2) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      repeat (2) @(posedge i_mclk);
   endtask

   task pulse_clear();
      @(posedge i_mclk) clr <= 1'b1;
      @(posedge i_mclk) clr <= 1'b0;
   endtask

   // Slow ticks, each 16 fast cycles; records first tick that saw a timeout
   task ticks(input int n);
      hit = 0;
      for (int i = 1; i <= n; i++) begin
         @(posedge i_mclk) osc <= 1'b1;
         repeat (8) @(negedge i_mclk) if (tmo === 1'b1 && hit == 0) hit = i;
         @(posedge i_mclk) osc <= 1'b0;
         repeat (8) @(negedge i_mclk) if (tmo === 1'b1 && hit == 0) hit = i;
      end
   endtask

   initial begin
      i_rst_n = 1'b0; i_bus = '0; cps = 5'h1f; cen = 2'h0;
      osc = 1'b0; slp = 1'b0; clr = 1'b0; cyc = 0; n_errors = 0; num_checks = 0;
      rv = $urandom(32'hcbe8);
      repeat (2) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      repeat (2) @(posedge i_mclk);
      rd(wdog_pkg::ADDR_CTRL, rv);
      check("ctrl reset", rv, 8'h16);
      for (int i = 0; i < 8; i++) begin
         d = (i == 0) ? 8'hff : (i == 1) ? 8'h24 : 8'($urandom);
         wr(wdog_pkg::ADDR_CTRL, d);
         rd(wdog_pkg::ADDR_CTRL, rv);
         check("ctrl write", rv, {2'h0, d[5:0]});
      end
      for (int k = 0; k < 4; k++) begin
         cen <= 2'(k);
         for (int b = 0; b < 2; b++) begin
            wr(wdog_pkg::ADDR_CTRL, {7'h00, 1'(b)});
            @(negedge i_mclk);
            check("running", {7'h00, run}, (k == 1) ? 8'(b) : 8'(k / 2));
         end
      end
      cen <= wdog_pkg::CFG_EN_SW;
      wr(wdog_pkg::ADDR_MASK, 8'h03);
      foreach (codes[j]) begin
         wr(wdog_pkg::ADDR_CTRL, {2'h0, codes[j], 1'b1});
         pulse_clear();
         ticks(exp_ticks(codes[j]) + 2);
         check("timeout tick", 8'(hit), 8'(exp_ticks(codes[j])));
      end
      wr(wdog_pkg::ADDR_CTRL, 8'h00);
      rd(wdog_pkg::ADDR_STATUS, rv);
      check("status", rv, 8'h01);
      check("irq set", {7'h00, irq}, 8'h01);
      wr(wdog_pkg::ADDR_MASK, 8'h00);
      @(negedge i_mclk);
      check("irq masked", {7'h00, irq}, 8'h00);
      wr(wdog_pkg::ADDR_MASK, 8'h03);
      wr(wdog_pkg::ADDR_STATUS, 8'h01);
      @(negedge i_mclk);
      check("irq cleared", {7'h00, irq}, 8'h00);
      wr(wdog_pkg::ADDR_CTRL, 8'h01);
      pulse_clear();
      ticks(20);
      check("no early timeout", 8'(hit), 8'h00);
      @(posedge i_mclk) slp <= 1'b1;
      repeat (4) @(posedge i_mclk);
      slp <= 1'b0;
      ticks(34);
      check("timeout after wake", 8'(hit), 8'h20);
      rd(wdog_pkg::ADDR_STATUS, rv);
      check("status wake", rv, 8'h03);
      d = 8'($urandom_range(18, 0));
      do_reset(d[4:0]);
      rd(wdog_pkg::ADDR_CTRL, rv);
      check("ctrl cfg reset", rv, {2'h0, d[4:0], 1'b0});
      wr(wdog_pkg::ADDR_CTRL, {2'h0, ~d[4:0], 1'b0});
      rd(wdog_pkg::ADDR_CTRL, rv);
      check("ctrl read only", rv, {2'h0, d[4:0], 1'b0});
      summarize();
   end
endmodule
